// ---- core/shift_unit_pkg.sv ----
// constants and carriers for the universal serial shift unit
//
// Behaviour
// - one 8-bit shift register, copied into a separate buffer register
// - shift register top bit drives one of two pins, chosen by wire mode
// - with external clock, a latch delays output changes to the edge opposite the sampling edge; internal clocks leave it transparent
// - serial input always comes from the data-in pin
// - 4-bit counter is readable, writable, and its overflow requests an interrupt
// - with internal clocks, shift register and counter advance from the same selected clock
// - with external clock the counter counts both serial clock edges, or toggle strobes when strobe counting is set
// - clock source: serial clock pin, timer 0 compare match, or software strobe
// - two-wire start condition can raise an interrupt
// - two-wire mode can hold clock low after start or counter overflow
// - three-wire mode acts as SPI modes 0 and 1, no slave select
// - two linked units exchange their bytes after eight clock cycles
// - edge select clear: sample and shift rising, output changes falling; set: swapped
// - sixteen counted edges overflow the counter and set the overflow flag
// - overflow interrupt can wake the processor from idle
// - writing one to overflow flag clears it and loads counter with the written count bits
// - external rising clock with strobe counting: toggle strobe toggles pin, advances counter
// - alternating strobe writes shift at half the processor clock
package shift_unit_pkg;

  localparam logic [7:0] SR_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;
  localparam int SYNC_PINS = 2;
  localparam int PIN_CLK = 1;
  localparam int PIN_DI = 0;

  // serial_control_register layout, msb first
  typedef struct packed {
    logic start_ie;
    logic ovf_ie;
    logic [1:0] wire_mode;
    logic external_clock_select;
    logic clock_edge_select;
    logic software_clock_strobe;
    logic clock_toggle_strobe;
  } ctrl_s;

  // serial_status_register layout, msb first
  typedef struct packed {
    logic start_flag;
    logic counter_overflow_flag;
    logic [1:0] reserved;
    logic [3:0] counter;
  } status_s;

  localparam ctrl_s CTRL_RST = '0;

endpackage

// ---- core/serial_shift_unit.sv ----
// universal serial shift unit: shift register, buffer, edge counter, pin logic
`timescale 1ns/1ps
module serial_shift_unit (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // control register port
  input wire logic ctrl_wr,
  input wire shift_unit_pkg::ctrl_s ctrl_wdata,
  output shift_unit_pkg::ctrl_s ctrl_rdata,
  // data and buffer
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] serial_shift_register,
  output logic [7:0] shift_buffer_copy,
  // status register port
  input wire logic status_wr,
  input wire shift_unit_pkg::status_s status_wdata,
  output shift_unit_pkg::status_s serial_status_register,
  // interrupt requests
  output logic overflow_irq,
  output logic start_irq,
  // timer 0 compare match, same clock
  input wire logic timer0_match,
  // port direction bits
  input wire logic clock_pin_drive,
  input wire logic data_out_drive,
  // serial clock pin
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  // data pins
  input wire logic serial_data_in_pin,
  output logic data_out_pin,
  output logic data_out_oe_n,
  output logic sda_o,
  output logic sda_oe_n
);

  function automatic logic is_two_wire(input logic [1:0] wm);
    is_two_wire = (wm == shift_unit_pkg::WM_TWO) || (wm == shift_unit_pkg::WM_TWO_HOLD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [shift_unit_pkg::SYNC_PINS-1:0] pins_in;
  logic [shift_unit_pkg::SYNC_PINS-1:0] sync1_r;
  logic [shift_unit_pkg::SYNC_PINS-1:0] sync2_r;
  logic [shift_unit_pkg::SYNC_PINS-1:0] last_r;

  assign pins_in = {serial_clock_pin_i, serial_data_in_pin};

  genvar g;
  generate
    for (g = 0; g < shift_unit_pkg::SYNC_PINS; g++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          last_r[g] <= 1'b0;
        end else if (clk_en) begin
          sync1_r[g] <= pins_in[g];
          sync2_r[g] <= sync1_r[g];
          last_r[g] <= sync2_r[g];
        end
      end
    end
  endgenerate

  logic sck_s;
  logic di_s;
  logic sck_rise;
  logic sck_fall;
  logic di_fall;

  assign sck_s = sync2_r[shift_unit_pkg::PIN_CLK];
  assign di_s = sync2_r[shift_unit_pkg::PIN_DI];
  assign sck_rise = sck_s && !last_r[shift_unit_pkg::PIN_CLK];
  assign sck_fall = !sck_s && last_r[shift_unit_pkg::PIN_CLK];
  assign di_fall = !di_s && last_r[shift_unit_pkg::PIN_DI];

  ////////////////////////////////////////////////////////////////////////////
  // control register

  shift_unit_pkg::ctrl_s ctrl_r;
  logic sw_clk;
  logic sw_toggle;

  // the toggle strobe acts only in the write cycle and is never stored; the clock strobe is stored only with external clock select
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r <= shift_unit_pkg::CTRL_RST;
    end else if (clk_en && ctrl_wr) begin
      ctrl_r <= ctrl_wdata;
      ctrl_r.clock_toggle_strobe <= 1'b0;
      ctrl_r.software_clock_strobe <= ctrl_wdata.software_clock_strobe &&
                                      ctrl_wdata.external_clock_select;
    end
  end

  assign ctrl_rdata = ctrl_r;
  assign sw_clk = ctrl_wr && ctrl_wdata.software_clock_strobe;
  assign sw_toggle = ctrl_wr && ctrl_wdata.clock_toggle_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection

  logic ext_sel;
  logic edge_sel;
  logic shift_tick;
  logic cnt_tick;

  assign ext_sel = ctrl_r.external_clock_select;
  assign edge_sel = ctrl_r.clock_edge_select;

  // external: sample on rising when edge select clear, else falling
  always_comb begin
    if (ext_sel) begin
      shift_tick = edge_sel ? sck_fall : sck_rise;
    end else if (edge_sel) begin
      shift_tick = timer0_match;
    end else begin
      shift_tick = sw_clk;
    end
  end

  // external clock counts edges, not bits; strobe counting overrides
  always_comb begin
    if (ext_sel && ctrl_r.software_clock_strobe) begin
      cnt_tick = sw_toggle;
    end else if (ext_sel) begin
      cnt_tick = sck_rise || sck_fall;
    end else begin
      cnt_tick = shift_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register and buffer copy

  logic [7:0] sr_r;
  logic [7:0] sr_nxt;
  logic [7:0] buffer_r;
  logic ovf_set;

  // a software write wins over a shift in the same cycle
  always_comb begin
    sr_nxt = sr_r;
    if (data_wr) begin
      sr_nxt = data_wdata;
    end else if (shift_tick) begin
      sr_nxt = {sr_r[6:0], di_s};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sr_r <= shift_unit_pkg::SR_RST;
    end else if (clk_en) begin
      sr_r <= sr_nxt;
    end
  end

  // buffer takes the completed byte so the shifter may run on
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      buffer_r <= shift_unit_pkg::SR_RST;
    end else if (clk_en && ovf_set) begin
      buffer_r <= sr_nxt;
    end
  end

  assign serial_shift_register = sr_r;
  assign shift_buffer_copy = buffer_r;

  ////////////////////////////////////////////////////////////////////////////
  // counter and flags

  logic [3:0] cnt_r;
  logic ovf_flag_r;
  logic start_flag_r;
  logic start_det;
  logic ovf_clr;
  logic start_clr;

  // a wrap in the cycle of a flag-clearing write still sets the flag
  assign ovf_set = cnt_tick && (cnt_r == shift_unit_pkg::CNT_MAX);
  assign ovf_clr = status_wr && status_wdata.counter_overflow_flag;
  assign start_clr = status_wr && status_wdata.start_flag;
  assign start_det = is_two_wire(ctrl_r.wire_mode) && di_fall && sck_s;

  // a status write loads the counter, so writing only the flag zeroes it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_r <= shift_unit_pkg::CNT_RST;
    end else if (clk_en) begin
      if (status_wr) begin
        cnt_r <= status_wdata.counter;
      end else if (cnt_tick) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovf_flag_r <= 1'b0;
    end else if (clk_en) begin
      ovf_flag_r <= ovf_set || (ovf_flag_r && !ovf_clr);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      start_flag_r <= 1'b0;
    end else if (clk_en) begin
      start_flag_r <= start_det || (start_flag_r && !start_clr);
    end
  end

  assign serial_status_register = '{start_flag: start_flag_r,
                                    counter_overflow_flag: ovf_flag_r,
                                    reserved: 2'h0,
                                    counter: cnt_r};
  assign overflow_irq = ovf_flag_r && ctrl_r.ovf_ie;
  assign start_irq = start_flag_r && ctrl_r.start_ie;

  ////////////////////////////////////////////////////////////////////////////
  // output latch and pins

  logic out_latch_r;
  logic clk_port_r;
  logic hold_start_r;
  logic scl_hold;
  logic two_wire;

  assign two_wire = is_two_wire(ctrl_r.wire_mode);

  // transparent only in the phase before the sampling edge, so the pin
  // changes on the opposite edge; internal clocks leave it transparent
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_latch_r <= 1'b0;
    end else if (clk_en && (!ext_sel || (sck_s == edge_sel))) begin
      out_latch_r <= sr_r[7];
    end
  end

  // port level of the clock pin, flipped by the toggle strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      clk_port_r <= 1'b0;
    end else if (clk_en && sw_toggle) begin
      clk_port_r <= !clk_port_r;
    end
  end

  // wait state begins at the master's first low clock after a start
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_start_r <= 1'b0;
    end else if (clk_en) begin
      if (!start_flag_r || !two_wire) begin
        hold_start_r <= 1'b0;
      end else if (sck_fall) begin
        hold_start_r <= 1'b1;
      end
    end
  end

  assign scl_hold = two_wire && (hold_start_r ||
                    (ctrl_r.wire_mode == shift_unit_pkg::WM_TWO_HOLD && ovf_flag_r));

  assign serial_clock_pin_o = clk_port_r && !scl_hold;
  assign serial_clock_pin_oe_n = !(clock_pin_drive || scl_hold);

  // three-wire: push-pull data out; two-wire: data line pulled low only
  assign data_out_pin = out_latch_r;
  assign data_out_oe_n = !(data_out_drive && ctrl_r.wire_mode == shift_unit_pkg::WM_THREE);
  assign sda_o = 1'b0;
  assign sda_oe_n = !(data_out_drive && two_wire && !out_latch_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_ovf_on_wrap:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && cnt_tick && !status_wr && cnt_r == 4'hF |=> ovf_flag_r && cnt_r == 4'h0)
    else $error("counter wrap did not set overflow flag");

  a_ovf_sticky:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    ovf_flag_r && !(clk_en && status_wr) |=> ovf_flag_r)
    else $error("overflow flag dropped without a clear");

  a_ovf_clear_zero:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && status_wr && status_wdata == 8'h40 && !cnt_tick |=> !ovf_flag_r && cnt_r == 4'h0)
    else $error("flag write did not clear flag and counter");

  a_buffer_copy:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && ovf_set |=> shift_buffer_copy == serial_shift_register)
    else $error("buffer missed the completed byte");

  a_di_sampled:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && shift_tick && !data_wr |=> sr_r == {$past(sr_r[6:0]), $past(di_s)})
    else $error("shift did not take data-in");

  a_both_edges:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && ext_sel && !ctrl_r.software_clock_strobe && (sck_rise || sck_fall) && !status_wr
    |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("external edge not counted");

  a_latch_phase:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    ext_sel && sck_s != edge_sel |=> $stable(out_latch_r))
    else $error("output changed on the sampling phase");

  a_toggle_pin:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && sw_toggle |=> clk_port_r != $past(clk_port_r))
    else $error("toggle strobe did not flip clock port");

  a_scl_overflow_hold:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctrl_r.wire_mode == 2'h3 && ovf_flag_r |-> !serial_clock_pin_oe_n && !serial_clock_pin_o)
    else $error("clock not held low after overflow");

  a_start_flag:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && start_det |=> start_flag_r)
    else $error("start condition not flagged");

endmodule

// ---- test/spi_peer_master.sv ----
// peer three-wire master model that drives the serial clock and data-in line
`timescale 1ns/1ps
module spi_peer_master (
  // serial clock and data towards the unit
  output logic sck,
  output logic mosi,
  // data from the unit
  input wire logic miso
);
  localparam int HALF_NS = 160;
  // clock rests low between frames, it never runs free
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
  end
  task automatic xfer(input logic [7:0] tx, input logic cpha, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (!cpha) begin
        mosi = tx[i];
      end
      #HALF_NS;
      sck = 1'b1;
      if (cpha) begin
        mosi = tx[i];
      end else begin
        rx[i] = miso;
      end
      #HALF_NS;
      if (cpha) begin
        rx[i] = miso;
      end
      sck = 1'b0;
    end
    #HALF_NS;
    // a released line must not keep showing the last bit
    mosi = ~mosi;
  endtask
  // level of the data line outside frames, used for two-wire start conditions
  task automatic set_data(input logic v);
    mosi = v;
  endtask
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the serial shift unit against a peer master
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ctrl_wr = 1'b0;
  shift_unit_pkg::ctrl_s ctrl_wdata = '0;
  shift_unit_pkg::ctrl_s ctrl_rdata;
  logic data_wr = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] serial_shift_register;
  logic [7:0] shift_buffer_copy;
  logic status_wr = 1'b0;
  shift_unit_pkg::status_s status_wdata = '0;
  shift_unit_pkg::status_s serial_status_register;
  logic timer0_match = 1'b0;
  logic clock_pin_drive = 1'b0;
  logic data_out_drive = 1'b1;
  logic clk_en = 1'b1;
  logic overflow_irq, start_irq, serial_clock_pin_o, serial_clock_pin_oe_n;
  logic data_out_pin, data_out_oe_n, sda_oe_n, peer_sck, peer_mosi;
  logic sck_line, miso_line;
  logic [7:0] peer_rx;
  int miscompares = 0;
  int check_count = 0;

  always #20 sys_clk = ~sys_clk;
  // the pin follows whoever drives it; an undriven data line shows no stale bit
  assign sck_line = serial_clock_pin_oe_n ? peer_sck : serial_clock_pin_o;
  assign miso_line = data_out_oe_n ? ~data_out_pin : data_out_pin;

  spi_peer_master peer (.sck(peer_sck), .mosi(peer_mosi), .miso(miso_line));

  serial_shift_unit uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .data_wr(data_wr), .data_wdata(data_wdata),
    .serial_shift_register(serial_shift_register), .shift_buffer_copy(shift_buffer_copy),
    .status_wr(status_wr), .status_wdata(status_wdata),
    .serial_status_register(serial_status_register),
    .overflow_irq(overflow_irq), .start_irq(start_irq), .timer0_match(timer0_match),
    .clock_pin_drive(clock_pin_drive), .data_out_drive(data_out_drive),
    .serial_clock_pin_i(sck_line), .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .serial_data_in_pin(peer_mosi),
    .data_out_pin(data_out_pin), .data_out_oe_n(data_out_oe_n),
    .sda_o(), .sda_oe_n(sda_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_ctrl(input logic [7:0] v);
    @(negedge sys_clk);
    ctrl_wdata = shift_unit_pkg::ctrl_s'(v);
    ctrl_wr = 1'b1;
    @(negedge sys_clk);
    ctrl_wr = 1'b0;
  endtask

  task automatic wr_stat(input logic [7:0] v);
    @(negedge sys_clk);
    status_wdata = shift_unit_pkg::status_s'(v);
    status_wr = 1'b1;
    @(negedge sys_clk);
    status_wr = 1'b0;
  endtask

  task automatic wr_data(input logic [7:0] v);
    @(negedge sys_clk);
    data_wdata = v;
    data_wr = 1'b1;
    @(negedge sys_clk);
    data_wr = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // full byte exchange with the peer on the external clock, either edge choice
  task automatic t_ext(input logic cpha, input logic [7:0] tx, input logic [7:0] rx);
    logic [7:0] cv;
    cv = cpha ? 8'h5C : 8'h58;
    wr_stat(8'h40);
    wr_data(tx);
    wr_ctrl(cv);
    @(negedge sys_clk);
    check(ctrl_rdata, cv);
    check({7'h00, data_out_oe_n}, 8'h00);
    peer.xfer(rx, cpha, peer_rx);
    repeat (8) @(negedge sys_clk);
    check(serial_shift_register, rx);
    check(shift_buffer_copy, rx);
    check(peer_rx, tx);
    check(serial_status_register, 8'h40);
    check({7'h00, overflow_irq}, 8'h01);
    wr_stat(8'h40);
    @(negedge sys_clk);
    check(serial_status_register, 8'h00);
    check({7'h00, overflow_irq}, 8'h00);
  endtask

  // alternating strobe writes every cycle, counter preset to wrap after eight
  task automatic t_fast();
    wr_stat(8'h08);
    wr_data(8'h00);
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      ctrl_wdata = shift_unit_pkg::ctrl_s'(i[0] ? 8'h13 : 8'h11);
      ctrl_wr = 1'b1;
    end
    @(negedge sys_clk);
    ctrl_wr = 1'b0;
    @(negedge sys_clk);
    check(serial_status_register, 8'h40);
    check(serial_shift_register, {8{peer_mosi}});
    repeat (4) @(negedge sys_clk);
    check(serial_status_register, 8'h40);
  endtask

  task automatic t_timer();
    wr_stat(8'h40);
    wr_data(8'h80);
    wr_ctrl(8'h14);
    repeat (3) begin
      @(negedge sys_clk);
      timer0_match = 1'b1;
      @(negedge sys_clk);
      timer0_match = 1'b0;
    end
    @(negedge sys_clk);
    check(serial_status_register, 8'h03);
    check(serial_shift_register, {5'h00, {3{peer_mosi}}});
    // a match while the enable is low must be lost
    @(negedge sys_clk);
    clk_en = 1'b0;
    timer0_match = 1'b1;
    @(negedge sys_clk);
    timer0_match = 1'b0;
    clk_en = 1'b1;
    @(negedge sys_clk);
    check(serial_status_register, 8'h03);
  endtask

  // the unit makes its own clock pin by toggle strobes counted one by one
  task automatic t_toggle();
    @(negedge sys_clk);
    clock_pin_drive = 1'b1;
    wr_stat(8'h40);
    wr_data(8'h00);
    // strobe counting is taken from the stored mode, so select it first
    wr_ctrl(8'h1A);
    repeat (16) begin
      wr_ctrl(8'h1B);
      repeat (6) @(negedge sys_clk);
    end
    check(ctrl_rdata, 8'h1A);
    check(serial_status_register, 8'h40);
    check(serial_shift_register, {8{peer_mosi}});
    check({7'h00, serial_clock_pin_o}, 8'h00);
    clock_pin_drive = 1'b0;
  endtask

  // two-wire slave: start detection, start wait state and overflow wait state
  task automatic t_two();
    peer.set_data(1'b1);
    wr_stat(8'h40);
    clock_pin_drive = 1'b1;
    wr_ctrl(8'hB8);
    wr_ctrl(8'hB9);
    repeat (4) @(negedge sys_clk);
    peer.set_data(1'b0);
    repeat (4) @(negedge sys_clk);
    check(serial_status_register, 8'h81);
    check({7'h00, start_irq}, 8'h01);
    wr_ctrl(8'hB9);
    repeat (4) @(negedge sys_clk);
    clock_pin_drive = 1'b0;
    @(negedge sys_clk);
    check({6'h00, serial_clock_pin_oe_n, serial_clock_pin_o}, 8'h00);
    wr_stat(8'h8F);
    @(negedge sys_clk);
    check({6'h00, serial_clock_pin_oe_n, start_irq}, 8'h02);
    clock_pin_drive = 1'b1;
    wr_ctrl(8'hB9);
    repeat (8) @(negedge sys_clk);
    clock_pin_drive = 1'b0;
    @(negedge sys_clk);
    check(serial_status_register, 8'h41);
    check({6'h00, serial_clock_pin_oe_n, serial_clock_pin_o}, 8'h00);
    wr_stat(8'h40);
    @(negedge sys_clk);
    check({7'h00, serial_clock_pin_oe_n}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(serial_shift_register, 8'h00);
    check(serial_status_register, 8'h00);
    check(ctrl_rdata, 8'h00);
    check({6'h00, data_out_oe_n, sda_oe_n}, 8'h03);
    t_ext(1'b0, 8'hA5, 8'h3C);
    t_ext(1'b1, 8'h5A, 8'hC3);
    t_fast();
    t_timer();
    t_toggle();
    t_two();
    test_done();
  end

  // a hang anywhere is cut short here
  initial begin
    #3_000_000;
    miscompares++;
    test_done();
  end
endmodule
